//--- include/dpm_host_pkg.sv
package dpm_host_pkg;

	////////////////////////////////////////////////////////////////////////
	// device memory map
	localparam int          ADDR_W        = 14;
	localparam int          DATA_W        = 16;
	localparam logic [13:0] MBOX_RIGHT    = 14'h3FFF;
	localparam logic [13:0] MBOX_LEFT     = 14'h3FFE;
	localparam logic [13:0] SAMPLE_ADDR   = 14'h0000;
	localparam logic [13:0] DRAIN_ADDR    = 14'h0001;

	////////////////////////////////////////////////////////////////////////
	// controller registers, word offsets on the wishbone side
	localparam logic [5:0]  REG_CTRL      = 6'h00;
	localparam logic [5:0]  REG_ADDR      = 6'h01;
	localparam logic [5:0]  REG_WDATA     = 6'h02;
	localparam logic [5:0]  REG_RDATA     = 6'h03;
	localparam logic [5:0]  REG_STATUS    = 6'h04;

	// control fields
	localparam int          CTRL_START    = 0;
	localparam int          CTRL_WRITE    = 1;
	localparam int          CTRL_LO_EN    = 2;
	localparam int          CTRL_HI_EN    = 3;
	localparam int          CTRL_CONV     = 4;
	localparam int          CTRL_SPECIAL_FUNC_EN_N     = 5;
	localparam logic [7:0]  CTRL_RESET    = 8'h0C;

	// status fields
	localparam int          ST_BUSY       = 0;
	localparam int          ST_DONE       = 1;
	localparam int          ST_COLL       = 2;
	localparam int          ST_LOST       = 3;
	localparam int          ST_IRQ        = 4;
	localparam int          ST_COLL_NOW   = 5;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int          CLK_MHZ       = 100;
	localparam int          SYNC_STAGES   = 2;
	localparam int          T_SETUP_NS    = 10;
	localparam int          T_HOLD_NS     = 10;
	localparam int          T_ACCESS_NS   = 65;
	localparam int          T_WRITE_NS    = 55;
	localparam int          T_DHOLD_NS    = 10;
	localparam int          T_RECOVER_NS  = 20;
	localparam logic [7:0]  CYC_SETUP     = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  CYC_HOLD      = 8'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  CYC_ACCESS    = 8'((T_ACCESS_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES);
	localparam logic [7:0]  CYC_WRITE     = 8'((T_WRITE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  CYC_DHOLD     = 8'((T_DHOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  CYC_RECOVER   = 8'((T_RECOVER_NS * CLK_MHZ + 999) / 1000);

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic sel_n;
		logic latch_n;
		logic we_n;
		logic oe_n;
		logic hi_n;
		logic lo_n;
	} pin_ctrl_t;

	localparam pin_ctrl_t PIN_IDLE = 6'h3F;

	typedef struct packed {
		logic [13:0] addr;
		logic [15:0] wdata;
		logic        write;
		logic        hi_en;
		logic        lo_en;
		logic        conv;
	} op_t;

	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_ADDR    = 3'b001,
		S_HOLD    = 3'b010,
		S_STROBE  = 3'b011,
		S_RELEASE = 3'b100,
		S_RECOVER = 3'b101
	} state_t;

endpackage

//--- hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
	import dpm_host_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '1;
			q      <= '1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

//--- hdl/phase_timer.sv
`timescale 1ns/1ps
module phase_timer
	import dpm_host_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [7:0] load_val,
	output logic            expired
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;

	// expiry must not look at load: the sequencer derives load from expiry
	assign expired = (cnt_q == 8'h01);
	assign cnt_d   = load ? load_val : ((cnt_q > 8'h01) ? cnt_q - 8'h01 : cnt_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

//--- hdl/dpm_host.sv
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module dpm_host
	import dpm_host_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output pin_ctrl_t        pin_ctrl,
	output logic      [13:0] addr_out,
	output logic      [15:0] bus_out,
	output logic      [15:0] bus_oe,
	input  wire logic [15:0] bus_in,
	input  wire logic        mailbox_irq_n,
	input  wire logic        collision_flag_n,
	output logic             special_func_en_n,
	output logic             right_if_select
);

	////////////////////////////////////////////////////////////////////////
	// reset release

	logic [1:0] rst_pipe_q;
	logic       rst_n;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_pipe_q <= 2'b00;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe_q[1];

	////////////////////////////////////////////////////////////////////////
	// pin inputs

	logic [17:0] pins_raw;
	logic [17:0] pins_s;
	logic [15:0] bus_s;
	logic        irq_s_n;
	logic        coll_s_n;

	assign pins_raw = {mailbox_irq_n, collision_flag_n, bus_in};

	pin_sync #(
		.W (18)
	) u_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     (pins_raw),
		.q     (pins_s)
	);

	assign bus_s    = pins_s[15:0];
	assign coll_s_n = pins_s[16];
	assign irq_s_n  = pins_s[17];

	////////////////////////////////////////////////////////////////////////
	// wishbone slave decode

	logic       ack_q;
	logic       acc;
	logic       wr0;
	logic       wr1;
	logic [5:0] widx;
	logic       hit_ctrl;
	logic       hit_addr;
	logic       hit_wdata;
	logic       hit_rdata;
	logic       hit_status;

	assign acc        = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr0        = acc && wb_we_i && wb_sel_i[0];
	assign wr1        = acc && wb_we_i && wb_sel_i[1];
	assign widx       = wb_adr_i[7:2];
	assign hit_ctrl   = (widx == REG_CTRL);
	assign hit_addr   = (widx == REG_ADDR);
	assign hit_wdata  = (widx == REG_WDATA);
	assign hit_rdata  = (widx == REG_RDATA);
	assign hit_status = (widx == REG_STATUS);

	////////////////////////////////////////////////////////////////////////
	// software registers

	logic [7:0]  ctrl_q;
	logic [7:0]  ctrl_d;
	logic [13:0] op_addr_q;
	logic [13:0] op_addr_d;
	logic [15:0] op_wdata_q;
	logic [15:0] op_wdata_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        done_q;
	logic        done_d;
	logic        coll_q;
	logic        coll_d;
	logic        lost_q;
	logic        lost_d;
	logic        busy_q;
	logic        start;
	logic        done_set;
	logic        coll_set;
	logic        lost_set;
	logic        rd_set;
	logic [15:0] rd_capture;
	logic        w1c;

	// start is refused while an access is running
	assign start      = wr0 && hit_ctrl && wb_dat_i[CTRL_START] && !busy_q;
	assign ctrl_d     = (wr0 && hit_ctrl) ? {wb_dat_i[7:1], 1'b0} : ctrl_q;
	assign op_addr_d  = {wr1 && hit_addr ? wb_dat_i[13:8] : op_addr_q[13:8],
	                     wr0 && hit_addr ? wb_dat_i[7:0]  : op_addr_q[7:0]};
	assign op_wdata_d = {wr1 && hit_wdata ? wb_dat_i[15:8] : op_wdata_q[15:8],
	                     wr0 && hit_wdata ? wb_dat_i[7:0]  : op_wdata_q[7:0]};
	assign rdata_d    = rd_set ? rd_capture : rdata_q;
	assign w1c        = wr0 && hit_status;

	// set wins over a clear in the same cycle
	assign done_d = done_set | (done_q & ~(w1c & wb_dat_i[ST_DONE]));
	assign coll_d = coll_set | (coll_q & ~(w1c & wb_dat_i[ST_COLL]));
	assign lost_d = lost_set | (lost_q & ~(w1c & wb_dat_i[ST_LOST]));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q     <= CTRL_RESET;
			op_addr_q  <= 14'h0000;
			op_wdata_q <= 16'h0000;
			rdata_q    <= 16'h0000;
			done_q     <= 1'b0;
			coll_q     <= 1'b0;
			lost_q     <= 1'b0;
		end else begin
			ctrl_q     <= ctrl_d;
			op_addr_q  <= op_addr_d;
			op_wdata_q <= op_wdata_d;
			rdata_q    <= rdata_d;
			done_q     <= done_d;
			coll_q     <= coll_d;
			lost_q     <= lost_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux

	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic [31:0] dat_q;

	assign status_word = {26'h0, ~coll_s_n, ~irq_s_n, lost_q, coll_q, done_q, busy_q};
	assign rd_word     = hit_ctrl   ? {24'h0, ctrl_q} :
	                     hit_addr   ? {18'h0, op_addr_q} :
	                     hit_wdata  ? {16'h0, op_wdata_q} :
	                     hit_rdata  ? {16'h0, rdata_q} :
	                     hit_status ? status_word : 32'h0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			ack_q <= acc;
			dat_q <= acc ? rd_word : dat_q;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	////////////////////////////////////////////////////////////////////////
	// access sequencer

	state_t      state_q;
	state_t      state_d;
	op_t         op_q;
	op_t         op_d;
	pin_ctrl_t   pins_q;
	pin_ctrl_t   pins_d;
	logic [13:0] aout_q;
	logic [13:0] aout_d;
	logic [15:0] dout_q;
	logic [15:0] dout_d;
	logic [15:0] doe_q;
	logic [15:0] doe_d;
	logic        busy_d;
	logic        t_load;
	logic [7:0]  t_val;
	logic        t_exp;
	logic [15:0] lane_mask;
	pin_ctrl_t   strobe_pins;
	op_t         new_op;

	phase_timer u_timer (
		.clk      (ref_clk),
		.rst_n    (rst_n),
		.load     (t_load),
		.load_val (t_val),
		.expired  (t_exp)
	);

	assign new_op = '{addr: op_addr_q, wdata: op_wdata_q, write: ctrl_q[CTRL_WRITE],
	                  hi_en: ctrl_q[CTRL_HI_EN], lo_en: ctrl_q[CTRL_LO_EN],
	                  conv: ctrl_q[CTRL_CONV]};

	// per-lane enables follow the byte enables
	assign lane_mask = {{8{op_q.hi_en}}, {8{op_q.lo_en}}};

	// strobe phase: write enable low for writes, output enable low for reads
	assign strobe_pins = '{sel_n: 1'b0, latch_n: 1'b1, we_n: ~op_q.write, oe_n: op_q.write,
	                       hi_n: ~op_q.hi_en, lo_n: ~op_q.lo_en};

	assign rd_capture = bus_s & lane_mask;
	assign coll_set   = (state_q == S_STROBE) && !coll_s_n;
	assign lost_set   = coll_set && op_q.write;
	assign rd_set     = (state_q == S_STROBE) && t_exp && !op_q.write;
	assign done_set   = (state_q == S_RECOVER) && t_exp;

	always_comb begin
		state_d = state_q;
		op_d    = op_q;
		pins_d  = pins_q;
		aout_d  = aout_q;
		dout_d  = dout_q;
		doe_d   = doe_q;
		busy_d  = busy_q;
		t_load  = 1'b0;
		t_val   = 8'h00;
		unique case (state_q)
			S_IDLE: begin
				if (start) begin
					op_d          = new_op;
					busy_d        = 1'b1;
					pins_d.sel_n  = 1'b0;
					t_load        = 1'b1;
					if (new_op.conv) begin
						aout_d  = new_op.addr;
						state_d = S_ADDR;
						t_val   = CYC_SETUP;
					end else begin
						pins_d.latch_n = 1'b0;
						dout_d         = {2'b00, new_op.addr};
						doe_d          = 16'hFFFF;
						state_d        = S_ADDR;
						t_val          = CYC_SETUP;
					end
				end
			end
			S_ADDR: begin
				if (t_exp) begin
					pins_d.latch_n = 1'b1;
					state_d        = S_HOLD;
					t_load         = 1'b1;
					t_val          = CYC_HOLD;
				end
			end
			S_HOLD: begin
				if (t_exp) begin
					// bus turns from address to data only after the hold
					pins_d  = strobe_pins;
					dout_d  = op_q.wdata;
					doe_d   = op_q.write ? lane_mask : 16'h0000;
					state_d = S_STROBE;
					t_load  = 1'b1;
					t_val   = op_q.write ? CYC_WRITE : CYC_ACCESS;
				end
			end
			S_STROBE: begin
				if (t_exp) begin
					// strobe rises before select, so the write lands on it
					pins_d.we_n = 1'b1;
					pins_d.oe_n = 1'b1;
					state_d     = S_RELEASE;
					t_load      = 1'b1;
					t_val       = CYC_DHOLD;
				end
			end
			S_RELEASE: begin
				if (t_exp) begin
					pins_d  = PIN_IDLE;
					doe_d   = 16'h0000;
					state_d = S_RECOVER;
					t_load  = 1'b1;
					t_val   = CYC_RECOVER;
				end
			end
			S_RECOVER: begin
				if (t_exp) begin
					busy_d  = 1'b0;
					state_d = S_IDLE;
				end
			end
			default: begin
				pins_d  = PIN_IDLE;
				doe_d   = 16'h0000;
				busy_d  = 1'b0;
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			op_q    <= '0;
			pins_q  <= PIN_IDLE;
			aout_q  <= 14'h0000;
			dout_q  <= 16'h0000;
			doe_q   <= 16'h0000;
			busy_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q    <= op_d;
			pins_q  <= pins_d;
			aout_q  <= aout_d;
			dout_q  <= dout_d;
			doe_q   <= doe_d;
			busy_q  <= busy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// static pins

	logic special_func_en_n_n_q;
	logic rsel_q;

	// mode pins only change between accesses, never mid-cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			special_func_en_n_n_q <= 1'b1;
			rsel_q   <= 1'b1;
		end else if (!busy_q) begin
			special_func_en_n_n_q <= ~ctrl_q[CTRL_SPECIAL_FUNC_EN_N];
			rsel_q   <= ~ctrl_q[CTRL_CONV];
		end
	end

	assign pin_ctrl          = pins_q;
	assign addr_out          = aout_q;
	assign bus_out           = dout_q;
	assign bus_oe            = doe_q;
	assign special_func_en_n = special_func_en_n_n_q;
	assign right_if_select   = rsel_q;

endmodule

//--- dv/dpm_host_chk.sv
`timescale 1ns/1ps
module dpm_host_chk
	import dpm_host_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire pin_ctrl_t   pin_ctrl,
	input  wire logic [15:0] bus_out,
	input  wire logic [15:0] bus_oe,
	input  wire logic        right_if_select
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	property p_addr_phase;
		$fell(pin_ctrl.sel_n) && right_if_select |-> !pin_ctrl.latch_n && bus_oe == 16'hFFFF;
	endproperty
	a_addr_phase: assert property (p_addr_phase) else $error("address phase malformed");

	property p_latch_pulse;
		$fell(pin_ctrl.latch_n) |=> pin_ctrl.latch_n && !pin_ctrl.sel_n && $stable(bus_out) && bus_oe == 16'hFFFF;
	endproperty
	a_latch_pulse: assert property (p_latch_pulse) else $error("latch edge without held address");

	property p_conv;
		!right_if_select |-> pin_ctrl.latch_n;
	endproperty
	a_conv: assert property (p_conv) else $error("latch pulsed in separate-address mode");

	property p_sel_hold;
		$fell(pin_ctrl.sel_n) |-> !pin_ctrl.sel_n [*8];
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select released early");

	property p_we_gate;
		!pin_ctrl.we_n |-> !pin_ctrl.sel_n && pin_ctrl.latch_n && bus_oe == {{8{!pin_ctrl.hi_n}}, {8{!pin_ctrl.lo_n}}};
	endproperty
	a_we_gate: assert property (p_we_gate) else $error("write lanes or select wrong");

	property p_store;
		$rose(pin_ctrl.we_n) |-> !pin_ctrl.sel_n && $stable(bus_out) && $stable(bus_oe);
	endproperty
	a_store: assert property (p_store) else $error("write data not held at store edge");

	property p_we_len;
		$fell(pin_ctrl.we_n) |-> !pin_ctrl.we_n [*6] ##1 pin_ctrl.we_n;
	endproperty
	a_we_len: assert property (p_we_len) else $error("write strobe length wrong");

	property p_read;
		!pin_ctrl.oe_n |-> pin_ctrl.we_n && !pin_ctrl.sel_n && bus_oe == 16'h0000;
	endproperty
	a_read: assert property (p_read) else $error("host drives bus during read");
endmodule

bind dpm_host dpm_host_chk dpm_host_chk_inst (
	.ref_clk         (ref_clk),
	.rstn            (rstn),
	.pin_ctrl        (pin_ctrl),
	.bus_out         (bus_out),
	.bus_oe          (bus_oe),
	.right_if_select (right_if_select)
);

//--- dv/dpm_dev_model.sv
`timescale 1ns/1ps
module dpm_dev_model
	import dpm_host_pkg::*;
(
	input  wire pin_ctrl_t   pc,
	input  wire logic [13:0] addr,
	input  wire logic [15:0] bus,
	input  wire logic        mode,
	input  wire logic        special_func_en_n_n,
	input  wire logic        busy_n,
	input  wire logic        poke_n,
	input  wire logic [1:0]  sample_in,
	output logic      [15:0] dev_out,
	output logic      [15:0] dev_oe,
	output logic             irq_n,
	output logic      [4:0]  drain_q
);
	logic [15:0] mem [0:16383];
	logic [13:0] lat_q;
	logic        wr_q = 1'b0;
	logic        rd_q = 1'b0;
	wire  [13:0] a   = mode ? lat_q : addr;
	wire         sf0 = !special_func_en_n_n && a == SAMPLE_ADDR;
	wire         sf1 = !special_func_en_n_n && a == DRAIN_ADDR;
	wire         rd  = !pc.sel_n && !pc.oe_n && pc.we_n && pc.latch_n;

	////////////////////////////////////////////////////////////////////////
	// drain bits kept as register, 1 = pin pulled low
	assign dev_out = sf0 ? {14'h0000, sample_in} : sf1 ? {11'h000, drain_q} : mem[a];
	assign dev_oe  = {{8{rd && !pc.hi_n}}, {8{rd && !pc.lo_n}}};
	initial irq_n = 1'b0;
	always @(posedge pc.latch_n) if (!pc.sel_n) lat_q <= bus[13:0];
	always @(negedge pc.we_n) wr_q = !pc.sel_n;
	always @(negedge pc.oe_n) rd_q = !pc.sel_n && pc.we_n;
	// peer port writing our mailbox
	always @(negedge poke_n) irq_n = 1'b0;
	// first of the two rising edges stores, later one finds wr_q clear
	always @(posedge pc.we_n or posedge pc.sel_n) begin
		if (wr_q && busy_n && !sf0) begin
			if (!pc.lo_n) mem[a][7:0] = bus[7:0];
			if (!pc.hi_n) mem[a][15:8] = bus[15:8];
			if (sf1 && !pc.lo_n) drain_q = bus[4:0];
		end
		wr_q = 1'b0;
	end
	always @(posedge pc.oe_n) begin
		if (rd_q && busy_n && a == MBOX_RIGHT) irq_n = 1'b1;
		rd_q = 1'b0;
	end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin fail_count++; $display("ERROR %s exp %h got %h", n, x, g); end end
module tb_top;
	import dpm_host_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        chk = 1'b0;
	logic        busy_n = 1'b1;
	logic        poke_n = 1'b1;
	logic [1:0]  smp = 2'b00;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic [31:0] seed = 32'h37EE3F43;
	logic [15:0] noise = 16'h0000;
	logic [15:0] w;
	logic [63:0] e;
	logic [63:0] exp_q [$];
	int          fail_count = 0;
	int          compares = 0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	pin_ctrl_t   pin_ctrl;
	logic [13:0] addr_out;
	logic [15:0] bus_out;
	logic [15:0] bus_oe;
	logic [15:0] dev_out;
	logic [15:0] dev_oe;
	logic        irq_n;
	logic        special_func_en_n_n;
	logic        rsel;
	logic [4:0]  drain_q;
	// released lines show a pattern that moves every cycle
	wire  [15:0] bus_w = (bus_oe & bus_out) | (~bus_oe & dev_oe & dev_out) | (~bus_oe & ~dev_oe & noise);

	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) noise <= {noise[14:0], ~noise[15]};

	dpm_host dpm_host_inst (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pin_ctrl(pin_ctrl), .addr_out(addr_out), .bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_w),
		.mailbox_irq_n(irq_n), .collision_flag_n(busy_n), .special_func_en_n(special_func_en_n_n), .right_if_select(rsel));
	dpm_dev_model dpm_dev_model_inst (.pc(pin_ctrl), .addr(addr_out), .bus(bus_w), .mode(rsel), .special_func_en_n_n(special_func_en_n_n),
		.busy_n(busy_n), .poke_n(poke_n), .sample_in(smp), .dev_out(dev_out), .dev_oe(dev_oe), .irq_n(irq_n),
		.drain_q(drain_q));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic finish_test();
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wb(input logic wr, input logic [5:0] r, input logic [31:0] d, input logic [63:0] x, input logic c);
		int n;
		@(posedge ref_clk);
		if (c)
			exp_q.push_back(x);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= {r, 2'b00};
		wdat <= d;
		chk <= c;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			finish_test();
		end
	endtask

	task automatic rd(input logic [5:0] r, input logic [31:0] m, input logic [31:0] x);
		wb(1'b0, r, 32'h0, {m, x}, 1'b1);
	endtask

	// mode bits first, start after, so pins settle before the access
	task automatic dev(input logic [5:0] c, input logic [13:0] a, input logic [15:0] d);
		int n;
		wb(1'b1, REG_ADDR, {18'h0, a}, 64'h0, 1'b0);
		wb(1'b1, REG_WDATA, {16'h0, d}, 64'h0, 1'b0);
		wb(1'b1, REG_CTRL, {26'h0, c & 6'h3E}, 64'h0, 1'b0);
		wb(1'b1, REG_CTRL, {26'h0, c}, 64'h0, 1'b0);
		n = 0;
		rdat = 32'h0;
		while (rdat[ST_DONE] !== 1'b1 && n < 40) begin
			wb(1'b0, REG_STATUS, 32'h0, 64'h0, 1'b0);
			n++;
		end
		if (n >= 40) begin
			fail_count++;
			finish_test();
		end
		wb(1'b1, REG_STATUS, 32'h00000002, 64'h0, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) if (wb_ack_o === 1'b1 && chk === 1'b1) begin
		e = exp_q.pop_front();
		`CHK("wb_dat_o", e[31:0], wb_dat_o & e[63:32])
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(REG_CTRL, 32'hFF, 32'h0C);
		rd(REG_STATUS, 32'h1F, 32'h10);
		rd(6'h20, 32'hFFFFFFFF, 32'h0);
		for (int m = 0; m < 2; m++) begin
			seed = xs(seed);
			w = {seed[15:8], ~seed[7:0]};
			dev(6'h0F | 6'(16 * m), 14'h0123, seed[15:0]);
			dev(6'h07 | 6'(16 * m), 14'h0123, ~seed[15:0]);
			dev(6'h0D | 6'(16 * m), 14'h0123, 16'h0);
			rd(REG_RDATA, 32'hFFFF, {16'h0, w});
			dev(6'h09 | 6'(16 * m), 14'h0123, 16'h0);
			rd(REG_RDATA, 32'hFFFF, {16'h0, w[15:8], 8'h00});
		end
		dev(6'h0D, MBOX_RIGHT, 16'h0);
		rd(REG_STATUS, 32'h10, 32'h00);
		poke_n <= 1'b0;
		@(posedge ref_clk);
		poke_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(REG_STATUS, 32'h10, 32'h10);
		dev(6'h0D, MBOX_LEFT, 16'h0);
		rd(REG_STATUS, 32'h10, 32'h10);
		busy_n <= 1'b0;
		dev(6'h0D, MBOX_RIGHT, 16'h0);
		rd(REG_STATUS, 32'h14, 32'h14);
		seed = xs(seed);
		dev(6'h0F, 14'h0123, seed[15:0]);
		rd(REG_STATUS, 32'h08, 32'h08);
		busy_n <= 1'b1;
		dev(6'h0D, 14'h0123, 16'h0);
		rd(REG_RDATA, 32'hFFFF, {16'h0, w});
		seed = xs(seed);
		smp <= seed[17:16];
		dev(6'h2F, DRAIN_ADDR, seed[15:0]);
		`CHK("drain_q", seed[4:0], drain_q)
		dev(6'h2D, DRAIN_ADDR, 16'h0);
		rd(REG_RDATA, 32'h1F, {27'h0, seed[4:0]});
		dev(6'h0D, DRAIN_ADDR, 16'h0);
		rd(REG_RDATA, 32'hFFFF, {16'h0, seed[15:0]});
		dev(6'h2D, SAMPLE_ADDR, 16'h0);
		rd(REG_RDATA, 32'h03, {30'h0, seed[17:16]});
		finish_test();
	end
endmodule
